// ### hdl/xlc_top.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module xlc_top
  import xlc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              ce_in,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rd_data_out,
  // Margining pins
  input  wire logic [LVL_W-1:0]  level_margin_pin_in,
  input  wire logic              margin_override_pin_in,
  // Analog controls
  output logic                   xo_enable_out,
  output logic                   pri_doubler_en_out,
  output logic                   sec_doubler_en_out,
  output logic      [CODE_W-1:0] load_cap_code_out,
  output logic      [CAP_W-1:0]  load_cap_ff_out,
  output logic                   margin_active_out
);
  // Configuration bytes
  logic [7:0] bias_q, bias_d;
  logic [7:0] imode_q, imode_d;
  logic [7:0] cp1_q, cp1_d;
  logic [7:0] cp2_q, cp2_d;
  logic [7:0] xoc_q, xoc_d;
  // Staged pairs
  logic [HI_W-1:0]   live_hi_q, live_hi_d;
  logic [CODE_W-1:0] live_code_q, live_code_d;
  logic [HI_W-1:0]   bank_hi_q, bank_hi_d;
  // Read pipeline
  logic [7:0] rd_q, rd_d;
  logic       bank_rd_q, bank_rd_d;
  logic       odd_q, odd_d;
  // Source pipeline
  logic              sel_live_q, sel_live_d;
  logic              sel_pin_q, sel_pin_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic [CAP_W-1:0]  cap_q, cap_d;
  logic              pin_q, pin_d;
  logic              xo_q, xo_d;
  logic              dbl1_q, dbl1_d;
  logic              dbl2_q, dbl2_d;

  logic [1:0]        src;
  logic [7:0]        bank_off;
  logic              bank_hit;
  logic              bank_we;
  logic [LVL_W-1:0]  pin_addr;
  logic [CODE_W-1:0] mem_a;
  logic [CODE_W-1:0] mem_b;
  logic [CAP_W-1:0]  cap_raw;

  assign src      = {xoc_q[SRC_HI_BIT], xoc_q[SRC_LO_BIT]};
  assign bank_off = addr_in - REG_BANK_LO;
  assign bank_hit = (addr_in >= REG_BANK_LO) && (addr_in <= REG_BANK_HI);
  // Bank pair commits on its odd (second) register only
  assign bank_we  = wr_in && bank_hit && bank_off[0];

  // Register writes
  always_comb begin
    bias_d      = bias_q;
    imode_d     = imode_q;
    cp1_d       = cp1_q;
    cp2_d       = cp2_q;
    xoc_d       = xoc_q;
    live_hi_d   = live_hi_q;
    live_code_d = live_code_q;
    bank_hi_d   = bank_hi_q;
    if (wr_in) begin
      unique case (addr_in)
        REG_IN_BIAS: bias_d  = wr_data_in;
        REG_IN_MODE: imode_d = wr_data_in;
        REG_PLL1_CP: cp1_d   = wr_data_in;
        REG_PLL2_CP: cp2_d   = wr_data_in;
        REG_XO_CTRL: xoc_d   = wr_data_in;
        // First write only stages; host orders the pair
        REG_LIVE_HI: live_hi_d = wr_data_in[HI_W-1:0];
        REG_LIVE_LO: live_code_d = {live_hi_q, wr_data_in};
        default: begin
          if (bank_hit && !bank_off[0]) begin
            bank_hi_d = wr_data_in[HI_W-1:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bias_q      <= RST_BYTE;
      imode_q     <= RST_BYTE;
      cp1_q       <= RST_BYTE;
      cp2_q       <= RST_BYTE;
      xoc_q       <= RST_BYTE;
      live_hi_q   <= '0;
      live_code_q <= '0;
      bank_hi_q   <= '0;
    end else if (ce_in) begin
      bias_q      <= bias_d;
      imode_q     <= imode_d;
      cp1_q       <= cp1_d;
      cp2_q       <= cp2_d;
      xoc_q       <= xoc_d;
      live_hi_q   <= live_hi_d;
      live_code_q <= live_code_d;
      bank_hi_q   <= bank_hi_d;
    end
  end

  // Register reads
  always_comb begin
    rd_d      = '0;
    bank_rd_d = 1'b0;
    odd_d     = bank_off[0];
    if (rd_in) begin
      unique case (addr_in)
        REG_IN_BIAS: rd_d = bias_q;
        REG_IN_MODE: rd_d = imode_q;
        REG_PLL1_CP: rd_d = cp1_q;
        REG_PLL2_CP: rd_d = cp2_q;
        REG_XO_CTRL: rd_d = xoc_q;
        REG_LIVE_HI: rd_d = {{(8-HI_W){1'b0}}, live_hi_q};
        REG_LIVE_LO: rd_d = live_code_q[7:0];
        REG_STAT_LO: rd_d = code_q[7:0];
        REG_STAT_HI: begin
          rd_d = {{(8-HI_W){1'b0}}, code_q[CODE_W-1:8]};
          rd_d[STAT_PIN_BIT] = pin_q;
          rd_d[STAT_LIV_BIT] = sel_live_q;
        end
        default: bank_rd_d = bank_hit;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_q      <= '0;
      bank_rd_q <= 1'b0;
      odd_q     <= 1'b0;
    end else if (ce_in) begin
      rd_q      <= rd_d;
      bank_rd_q <= bank_rd_d;
      odd_q     <= odd_d;
    end
  end

  // Bank entry read back straight from the memory's output register
  assign rd_data_out = !bank_rd_q ? rd_q :
                       odd_q ? mem_b[7:0] :
                       {{(8-HI_W){1'b0}}, mem_b[CODE_W-1:8]};

  // Level input arrives already resolved to one of eight settings
  assign pin_addr = sel_pin_d ? level_margin_pin_in : OVR_ENTRY;

  xlc_bank_mem #(
    .W (CODE_W),
    .N (BANK_N),
    .A (LVL_W)
  ) u_bank (
    .clk_in     (ref_clk_in),
    .rst_in     (sys_rst_in),
    .ce_in      (ce_in),
    .we_in      (bank_we),
    .waddr_in   (bank_off[3:1]),
    .wdata_in   ({bank_hi_q, wr_data_in}),
    .a_addr_in  (pin_addr),
    .a_data_out (mem_a),
    .b_addr_in  (bank_off[3:1]),
    .b_data_out (mem_b)
  );

  // Source select and capacitance scaling
  always_comb begin
    sel_pin_d  = 1'b0;
    sel_live_d = 1'b0;
    unique case (src)
      SRC_PIN_ONLY:     sel_pin_d = 1'b1;
      SRC_PIN_OVR_BANK: sel_pin_d = !margin_override_pin_in;
      SRC_PIN_OVR_LIVE: begin
        sel_pin_d  = !margin_override_pin_in;
        sel_live_d = margin_override_pin_in;
      end
      // Undefined combination falls back to the live pair
      SRC_RESERVED: sel_live_d = 1'b1;
    endcase
    pin_d   = sel_pin_q;
    code_d  = sel_live_q ? live_code_q : mem_a;
    // Code LSB is 14 fF (CAP_STEP_FF), not the nominal 0.02 pF step
    cap_raw = CAP_MIN_FF + CAP_W'(code_d) * CAP_STEP_FF;
    cap_d   = (cap_raw > CAP_MAX_FF) ? CAP_MAX_FF : cap_raw;
    xo_d    = imode_q[SEC_XO_BIT] && !imode_q[SEC_DIFF_BIT] &&
              bias_q[SEC_BIAS_BIT];
    dbl1_d  = cp1_q[DBL_BIT];
    dbl2_d  = cp2_q[DBL_BIT];
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sel_pin_q  <= 1'b0;
      sel_live_q <= 1'b0;
      pin_q      <= 1'b0;
      code_q     <= '0;
      cap_q      <= CAP_MIN_FF;
      xo_q       <= 1'b0;
      dbl1_q     <= 1'b0;
      dbl2_q     <= 1'b0;
    end else if (ce_in) begin
      sel_pin_q  <= sel_pin_d;
      sel_live_q <= sel_live_d;
      pin_q      <= pin_d;
      code_q     <= code_d;
      cap_q      <= cap_d;
      xo_q       <= xo_d;
      dbl1_q     <= dbl1_d;
      dbl2_q     <= dbl2_d;
    end
  end

  assign xo_enable_out      = xo_q;
  assign pri_doubler_en_out = dbl1_q;
  assign sec_doubler_en_out = dbl2_q;
  assign load_cap_code_out  = code_q;
  assign load_cap_ff_out    = cap_q;
  assign margin_active_out  = pin_q;

  xo_enable_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in |=> xo_enable_out == ($past(imode_q[SEC_XO_BIT]) &&
              !$past(imode_q[SEC_DIFF_BIT]) && $past(bias_q[SEC_BIAS_BIT])))
    else $error("crystal enable does not match config bits");

  cap_scale_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (load_cap_ff_out >= CAP_MIN_FF) && (load_cap_ff_out <= CAP_MAX_FF) &&
    (load_cap_ff_out == CAP_MAX_FF ||
     load_cap_ff_out == CAP_MIN_FF + CAP_W'(load_cap_code_out) * CAP_STEP_FF))
    else $error("capacitance out of span or off scale");

  pin_only_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && src == SRC_PIN_ONLY) ##1 ce_in |=> margin_active_out)
    else $error("pin-only source not margining");

  ovr_bank_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && src == SRC_PIN_OVR_BANK && margin_override_pin_in) |->
      pin_addr == OVR_ENTRY ##1 (!sel_live_q && !sel_pin_q))
    else $error("override did not select bank pair");

  ovr_live_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && src == SRC_PIN_OVR_LIVE && margin_override_pin_in) ##1 ce_in
      |=> load_cap_code_out == $past(live_code_q) && !margin_active_out)
    else $error("override did not select live pair");

  level_sel_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && sel_pin_d) ##1 (ce_in && !sel_live_q)
      |=> load_cap_code_out == $past(mem_a))
    else $error("level setting not applied");

  level_addr_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && sel_pin_d) ##1 (ce_in && !sel_live_q) |=>
      load_cap_code_out == $past(u_bank.mem_q[level_margin_pin_in], 2))
    else $error("level pin not addressing bank");

  first_hold_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && wr_in && addr_in == REG_LIVE_HI) |=> $stable(live_code_q))
    else $error("first register write changed live code");

  pair_commit_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && wr_in && addr_in == REG_LIVE_LO) |=>
      live_code_q == {$past(live_hi_q), $past(wr_data_in)})
    else $error("second register write did not commit pair");

  doubler_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in |=> pri_doubler_en_out == $past(cp1_q[DBL_BIT]) &&
              sec_doubler_en_out == $past(cp2_q[DBL_BIT]))
    else $error("doubler enable does not match register");

  pin_follow_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && src == SRC_PIN_OVR_BANK && !margin_override_pin_in) ##1 ce_in
      |=> margin_active_out)
    else $error("low override did not keep pin margining");

  live_pin_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && src == SRC_PIN_OVR_LIVE && !margin_override_pin_in) ##1 ce_in
      |=> margin_active_out)
    else $error("low override did not keep pin margining");

  bank_commit_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && bank_we) |=> u_bank.mem_q[$past(bank_off[3:1])] ==
      {$past(bank_hi_q), $past(wr_data_in)})
    else $error("bank pair not committed on second write");
endmodule
`default_nettype wire

// ### hdl/xlc_pkg.sv
package xlc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 10;
  localparam int HI_W   = 2;
  localparam int LVL_W  = 3;
  localparam int BANK_N = 8;
  localparam int CAP_W  = 15;

  // Register numbers
  localparam logic [7:0] REG_IN_BIAS  = 8'h1D;
  localparam logic [7:0] REG_IN_MODE  = 8'h32;
  localparam logic [7:0] REG_PLL1_CP  = 8'h39;
  localparam logic [7:0] REG_PLL2_CP  = 8'h48;
  localparam logic [7:0] REG_XO_CTRL  = 8'h56;
  localparam logic [7:0] REG_BANK_LO  = 8'h58;
  localparam logic [7:0] REG_BANK_HI  = 8'h67;
  localparam logic [7:0] REG_LIVE_HI  = 8'h68;
  localparam logic [7:0] REG_LIVE_LO  = 8'h69;
  localparam logic [7:0] REG_STAT_LO  = 8'hF0;
  localparam logic [7:0] REG_STAT_HI  = 8'hF1;

  // Field positions
  localparam int SEC_BIAS_BIT = 1;
  localparam int SEC_XO_BIT   = 7;
  localparam int SEC_DIFF_BIT = 6;
  localparam int DBL_BIT      = 4;
  localparam int SRC_HI_BIT   = 3;
  localparam int SRC_LO_BIT   = 2;
  localparam int STAT_PIN_BIT = 7;
  localparam int STAT_LIV_BIT = 6;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // Load source select, value of the two control bits; bank entry used on override
  localparam logic [1:0] SRC_PIN_OVR_BANK = 2'h0;
  localparam logic [1:0] SRC_PIN_ONLY     = 2'h1;
  localparam logic [1:0] SRC_PIN_OVR_LIVE = 2'h2;
  localparam logic [1:0] SRC_RESERVED     = 2'h3;
  localparam logic [2:0] OVR_ENTRY        = 3'h3;

  // Capacitance scale, femtofarads
  localparam logic [14:0] CAP_MIN_FF   = 15'h36B0;
  localparam logic [14:0] CAP_MAX_FF   = 15'h5DC0;
  localparam logic [14:0] CAP_STEP_FF  = 15'h000E;
  localparam int          LSB_DELTA_FF = 20;

  // Level pin scale, millivolts
  localparam int PIN_FS_MV   = 1800;
  localparam int PIN_STEP_MV = 200;
  localparam int PIN_LEVELS  = 8;
endpackage

// ### hdl/xlc_bank_mem.sv
`timescale 1ns/1ps
`default_nettype none
module xlc_bank_mem #(
  parameter int W = 10,
  parameter int N = 8,
  parameter int A = 3
) (
  // Clock and control
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  // Write port
  input  wire logic         we_in,
  input  wire logic [A-1:0] waddr_in,
  input  wire logic [W-1:0] wdata_in,
  // Read ports
  input  wire logic [A-1:0] a_addr_in,
  output logic      [W-1:0] a_data_out,
  input  wire logic [A-1:0] b_addr_in,
  output logic      [W-1:0] b_data_out
);
  logic [W-1:0] mem_q [N];
  logic [W-1:0] a_d;
  logic [W-1:0] b_d;

  always_comb begin
    a_d = mem_q[a_addr_in];
    b_d = mem_q[b_addr_in];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= '0;
      end
      a_data_out <= '0;
      b_data_out <= '0;
    end else if (ce_in) begin
      if (we_in) begin
        mem_q[waddr_in] <= wdata_in;
      end
      a_data_out <= a_d;
      b_data_out <= b_d;
    end
  end
endmodule
`default_nettype wire

// ### test/xlc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module xlc_board_model
  import xlc_pkg::*;
(
  // Clock
  input  wire logic             clk_in,
  // Requested pin states
  input  wire logic [LVL_W-1:0] level_req_in,
  input  wire logic             override_req_in,
  // Board pins
  output logic      [LVL_W-1:0] level_margin_pin_out,
  output logic                  margin_override_pin_out
);
  // Divider node lags a request by one cycle, like a slow RC
  always @(posedge clk_in) begin
    level_margin_pin_out    <= level_req_in;
    margin_override_pin_out <= override_req_in;
  end
endmodule
`default_nettype wire

// ### test/test_crystal_load_cap_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_crystal_load_cap_select;
  import xlc_pkg::*;
  logic              clk, rst, ce, wr, rd, ovr_req;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [LVL_W-1:0]  lvl_req, lvl_pin;
  logic              ovr_pin, xo, pdbl, sdbl, mact;
  logic [CODE_W-1:0] code;
  logic [CAP_W-1:0]  cap_ff;
  int                fails, compares;

  xlc_board_model i_board (.clk_in(clk), .level_req_in(lvl_req),
    .override_req_in(ovr_req), .level_margin_pin_out(lvl_pin),
    .margin_override_pin_out(ovr_pin));
  xlc_top i_dut (.ref_clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
    .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rdata), .level_margin_pin_in(lvl_pin),
    .margin_override_pin_in(ovr_pin), .xo_enable_out(xo),
    .pri_doubler_en_out(pdbl), .sec_doubler_en_out(sdbl),
    .load_cap_code_out(code), .load_cap_ff_out(cap_ff),
    .margin_active_out(mact));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", rdata, e);
  endtask

  // Source pipe is two cycles, pin model one more
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Pin requests change only on a rising edge
  task automatic pins(input logic [2:0] l, input logic o);
    @(posedge clk);
    lvl_req <= l;
    ovr_req <= o;
  endtask

  function automatic logic [9:0] code_of(input int k);
    return (k == 7) ? 10'h3FF : {2'(k), 8'(8'h11 * k)};
  endfunction

  // Clamp at the top of the array range
  function automatic logic [14:0] ff_of(input logic [9:0] c);
    int f;
    f = 14000 + 14 * c;
    return 15'((f > 24000) ? 24000 : f);
  endfunction

  task automatic test_reset();
    chk("code", code, 0);
    chk("cap", cap_ff, CAP_MIN_FF);
    chk("xo", xo, 0);
    chk("pri dbl", pdbl, 0);
    chk("active", mact, 0);
    $display("test reset done");
  endtask

  task automatic test_xo();
    wr_reg(REG_IN_MODE, 8'h80);
    wr_reg(REG_IN_BIAS, 8'h02);
    settle();
    chk("xo", xo, 1);
    wr_reg(REG_IN_MODE, 8'hC0);
    settle();
    chk("xo", xo, 0);
    wr_reg(REG_IN_MODE, 8'h80);
    wr_reg(REG_IN_BIAS, 8'hFD);
    settle();
    chk("xo", xo, 0);
    $display("test xo done");
  endtask

  task automatic test_dbl();
    wr_reg(REG_PLL1_CP, 8'h10);
    wr_reg(REG_PLL2_CP, 8'hEF);
    settle();
    chk("pri dbl", pdbl, 1);
    chk("sec dbl", sdbl, 0);
    wr_reg(REG_PLL2_CP, 8'h10);
    settle();
    chk("sec dbl", sdbl, 1);
    rd_reg(REG_PLL1_CP, 8'h10);
    $display("test doubler done");
  endtask

  // Override held high throughout: pin must still win
  task automatic test_pin();
    logic [9:0] c;
    wr_reg(REG_XO_CTRL, 8'h04);
    for (int k = 0; k < 8; k++) begin
      c = code_of(k);
      wr_reg(8'(REG_BANK_LO + 2 * k), {6'h0, c[9:8]});
      wr_reg(8'(REG_BANK_LO + 2 * k + 1), c[7:0]);
    end
    rd_reg(8'h62, 8'h01);
    rd_reg(8'h63, 8'h55);
    for (int k = 0; k < 8; k++) begin
      pins(3'(k), 1'b1);
      settle();
      chk("code", code, code_of(k));
      chk("active", mact, 1);
      chk("cap", cap_ff, ff_of(code_of(k)));
    end
    $display("test pin done");
  endtask

  task automatic test_bank_ovr();
    wr_reg(REG_XO_CTRL, 8'h00);
    settle();
    chk("code", code, code_of(3));
    chk("active", mact, 0);
    pins(3'h5, 1'b0);
    settle();
    chk("code", code, code_of(5));
    chk("active", mact, 1);
    $display("test bank override done");
  endtask

  task automatic test_live();
    wr_reg(REG_XO_CTRL, 8'h08);
    pins(3'h5, 1'b1);
    wr_reg(REG_LIVE_HI, 8'h02);
    settle();
    chk("code", code, 0);
    rd_reg(REG_LIVE_HI, 8'h02);
    wr_reg(REG_LIVE_LO, 8'h34);
    settle();
    chk("code", code, 10'h234);
    chk("cap", cap_ff, ff_of(10'h234));
    pins(3'h2, 1'b0);
    settle();
    chk("code", code, code_of(2));
    chk("active", mact, 1);
    wr_reg(8'h10, 8'hFF);
    rd_reg(8'h10, 8'h00);
    rd_reg(REG_XO_CTRL, 8'h08);
    // Undefined mode falls back to the live pair whatever the override
    wr_reg(REG_XO_CTRL, 8'h0C);
    settle();
    chk("code", code, 10'h234);
    chk("active", mact, 0);
    rd_reg(REG_STAT_LO, 8'h34);
    rd_reg(REG_STAT_HI, 8'h42);
    $display("test live done");
  endtask

  // Strobes while frozen must leave no trace; pin moves apply once ce returns
  task automatic test_ce();
    wr_reg(REG_XO_CTRL, 8'h04);
    settle();
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(REG_PLL1_CP, 8'h00);
    pins(3'h6, 1'b0);
    settle();
    chk("code", code, code_of(2));
    chk("pri dbl", pdbl, 1);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    chk("code", code, code_of(6));
    chk("pri dbl", pdbl, 1);
    $display("test ce done");
  endtask

  task automatic test_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("code", code, 0);
    chk("cap", cap_ff, CAP_MIN_FF);
    chk("pri dbl", pdbl, 0);
    chk("active", mact, 0);
    settle();
    chk("active", mact, 1);
    chk("code", code, 0);
    rd_reg(8'h5E, 8'h00);
    $display("test reset again done");
  endtask

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #50000;
    fails++;
    test_done();
  end

  initial begin
    fails    = 0;
    compares = 0;
    rst      = 1'b1;
    ce       = 1'b1;
    wr       = 1'b0;
    rd       = 1'b0;
    addr     = '0;
    wdata    = '0;
    lvl_req  = '0;
    ovr_req  = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    test_reset();
    test_xo();
    test_dbl();
    test_pin();
    test_bank_ovr();
    test_live();
    test_ce();
    test_rerst();
    test_done();
  end
endmodule
`default_nettype wire
